/* File: design/wdt_timed.sv */
// Watchdog timer with timed unlock sequence and Wishbone register port
// ****************************************
// ****************************************
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_timed #(
  parameter int OSC_DIV = `WDT_SYS_HZ / `WDT_OSC_HZ,
  parameter int BASE_CYCLES = `WDT_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic always_on_fuse_i,
  input wire logic restart_instruction_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dog_reset_o,
  output logic dog_reset_flag_o,
  output wdt_pkg::wdt_ctrl_t ctrl_o
);
  import wdt_pkg::*;

  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam int CW = `WDT_CNT_W;

  // ****************************************
  // Helpers
  // ****************************************

  // Number of oscillator cycles for a period code
  function automatic logic [CW-1:0] period_limit(input logic [2:0] p);
    period_limit = CW'(BASE_CYCLES) << p;
  endfunction

  // Byte address decode, word aligned
  function automatic logic adr_hit(input logic [7:0] a,
                                   input logic [7:0] base);
    adr_hit = (a[7:2] == base[7:2]);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic ack;
  logic req;
  logic wr_commit;
  logic ctl_wr;
  logic stat_wr;
  logic wr_unlock;
  logic wr_enable;
  logic [2:0] wr_period;
  logic [2:0] unlock_cnt;
  logic armed;
  logic unlock_set;
  logic en_reg;
  logic en_eff;
  logic [2:0] period;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [CW-1:0] count;
  logic expire;
  logic flag;
  logic [31:0] next_rdata;
  wdt_clear_t clr;

  // ****************************************
  // Wishbone slave
  // ****************************************

  // Request seen while ack is low; ack is one cycle, then released
  assign req = wb_cyc_i & wb_stb_i;

  // Registered ack, answer on the cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  assign wb_ack_o = ack;

  // A write lands on the same edge the master samples ack
  assign wr_commit = req & wb_we_i & ack & wb_sel_i[0];
  assign ctl_wr = wr_commit & adr_hit(wb_adr_i, `WDT_CTRL_ADR);
  assign stat_wr = wr_commit & adr_hit(wb_adr_i, `WDT_STAT_ADR);

  // Fields of the written control byte
  assign wr_unlock = wb_dat_i[`WDT_UNLOCK_BIT];
  assign wr_enable = wb_dat_i[`WDT_ENABLE_BIT];
  assign wr_period = wb_dat_i[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];

  // Read mux; unmapped words and reserved bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (adr_hit(wb_adr_i, `WDT_CTRL_ADR)) begin
      next_rdata[`WDT_UNLOCK_BIT] = armed;
      next_rdata[`WDT_ENABLE_BIT] = en_eff;
      next_rdata[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB] = period;
    end else if (adr_hit(wb_adr_i, `WDT_STAT_ADR)) begin
      next_rdata[`WDT_FLAG_BIT] = flag;
    end
  end

  // Read data held in flops, loaded while the request waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~ack) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ****************************************
  // Timed unlock window
  // ****************************************

  // Arming needs unlock and enable both written as one
  assign unlock_set = ctl_wr & wr_unlock & wr_enable;
  assign armed = (unlock_cnt != 3'h0);

  // Window counts down from four; the bit drops when it hits zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_cnt <= 3'h0;
    end else if (unlock_set) begin
      unlock_cnt <= `WDT_UNLOCK_CYCLES;
    end else if (ctl_wr) begin
      // A timed write consumes the window
      unlock_cnt <= 3'h0;
    end else if (armed) begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  // ****************************************
  // Enable and period
  // ****************************************

  // Level two forces enable; the stored bit is kept for level one
  assign en_eff = en_reg | always_on_fuse_i;

  // Setting enable is free; clearing needs an open window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= `WDT_ENABLE_RST;
    end else if (ctl_wr) begin
      if (wr_enable) begin
        en_reg <= 1'b1;
      end else if (armed) begin
        en_reg <= 1'b0;
      end
    end
  end

  // Period loads only inside the window, on either safety level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period <= `WDT_PERIOD_RST;
    end else if (ctl_wr && armed) begin
      period <= wr_period;
    end
  end

  assign ctrl_o.unlock = armed;
  assign ctrl_o.enable = en_eff;
  assign ctrl_o.period = period;

  // ****************************************
  // Oscillator tick
  // ****************************************

  // One-cycle enable at the 1 MHz watchdog rate; free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_W'(OSC_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  assign tick = (div_cnt == DIV_W'(OSC_DIV - 1));

  // ****************************************
  // Watchdog counter
  // ****************************************

  // All clear sources share one clock with the counter, so no
  // event can be half seen; a period change restarts the count
  assign clr.restart = restart_instruction_i;
  assign clr.disabled = ~en_eff;
  assign clr.chip_reset = rst_i;
  assign clr.reload = ctl_wr & armed & (wr_period != period);
  assign clr.expired = expire;

  // Expiry on the tick that completes the selected period
  assign expire = tick & en_eff & ~restart_instruction_i
                & (count == period_limit(period) - CW'(1));

  always_ff @(posedge clk_i) begin
    if (|clr) begin
      count <= '0;
    end else if (tick) begin
      count <= count + CW'(1);
    end
  end

  // Reset request pulse, exactly one system cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dog_reset_o <= 1'b0;
    end else begin
      dog_reset_o <= expire;
    end
  end

  // ****************************************
  // Watchdog reset flag
  // ****************************************

  // Survives chip reset; only power-on or a zero write clears it.
  // The set wins over a zero-write clear in the same cycle; power-on wins over the set.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      flag <= `WDT_FLAG_RST;
    end else if (dog_reset_o) begin
      flag <= 1'b1;
    end else if (stat_wr && !wb_dat_i[`WDT_FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  assign dog_reset_flag_o = flag;

  // ****************************************
  // Assertions
  // ****************************************

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack && !wb_we_i) |-> (wb_dat_o[31:5] == 27'h0))
    else $error("reserved control bits not zero");

  a_locked_disable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_wr && !armed && en_reg) |=> en_reg)
    else $error("enable cleared without unlock");

  a_unlock_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    unlock_set |=> (unlock_cnt == 3'h4))
    else $error("unlock window not opened at four");

  a_unlock_open: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (unlock_set ##1 (!ctl_wr)[*3]) |=> armed)
    else $error("unlock bit dropped before four cycles");

  a_unlock_expire: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (unlock_set ##1 (!ctl_wr)[*4]) |=> !armed)
    else $error("unlock bit not cleared after four cycles");

  a_period_locked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_wr && !armed) |=> $stable(period))
    else $error("period changed while locked");

  a_timed_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_wr && armed && !wr_unlock) |=>
      (period == $past(wr_period)) && (en_reg == $past(wr_enable)))
    else $error("timed write did not load enable and period");

  a_enable_free: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_wr && wr_enable) |=> en_eff)
    else $error("enable write ignored");

  a_start_disabled: assert property (
    @(posedge clk_i)
    rst_i |=> !en_reg && (count == '0))
    else $error("chip reset left enable or counter set");

  a_level_two_on: assert property (
    @(posedge clk_i) disable iff (rst_i)
    always_on_fuse_i |-> ctrl_o.enable)
    else $error("enable low in safety level two");

  a_level_two_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack && !wb_we_i && adr_hit(wb_adr_i, `WDT_CTRL_ADR)
      && always_on_fuse_i && $past(always_on_fuse_i))
      |-> wb_dat_o[`WDT_ENABLE_BIT])
    else $error("enable read low in safety level two");

  a_restart_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    restart_instruction_i |=> (count == '0) && !dog_reset_o)
    else $error("restart did not clear counter");

  a_disable_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !en_eff |=> (count == '0))
    else $error("counter runs while disabled");

  a_reload_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_wr && armed && (wr_period != period)) |=> (count == '0))
    else $error("period change did not restart the count");

  a_pulse_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dog_reset_o |=> !dog_reset_o)
    else $error("reset pulse longer than one cycle");

  a_expire_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    expire |=> dog_reset_o && (count == '0))
    else $error("expiry did not raise reset pulse");

  a_flag_sticky: assert property (
    @(posedge clk_i) disable iff (por_i)
    dog_reset_o |=> flag)
    else $error("watchdog reset flag not set");

  a_flag_clear: assert property (
    @(posedge clk_i) disable iff (por_i)
    (stat_wr && !wb_dat_i[`WDT_FLAG_BIT] && !dog_reset_o) |=> !flag)
    else $error("zero write did not clear the flag");

endmodule

/* File: design/wdt_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define WDT_CTRL_ADR 8'h00
`define WDT_STAT_ADR 8'h04

// ****************************************
// Field positions
// ****************************************
`define WDT_UNLOCK_BIT 4
`define WDT_ENABLE_BIT 3
`define WDT_PERIOD_MSB 2
`define WDT_PERIOD_LSB 0
`define WDT_FLAG_BIT 3

// ****************************************
// Reset values
// ****************************************
`define WDT_PERIOD_RST 3'h0
`define WDT_ENABLE_RST 1'b0
`define WDT_FLAG_RST 1'b0

// ****************************************
// Timing
// ****************************************
`define WDT_SYS_HZ 25000000
`define WDT_OSC_HZ 1000000
`define WDT_UNLOCK_CYCLES 3'h4
`define WDT_BASE_CYCLES 16384
`define WDT_CNT_W 22

`endif

/* File: design/wdt_pkg.sv */
// Types shared by the watchdog timer with timed unlock
package wdt_pkg;

  // Control register view as seen by the rest of the chip
  typedef struct packed {
    logic unlock;
    logic enable;
    logic [2:0] period;
  } wdt_ctrl_t;

  // Source of a counter clear, one bit each
  typedef struct packed {
    logic restart;
    logic disabled;
    logic chip_reset;
    logic reload;
    logic expired;
  } wdt_clear_t;

endpackage

/* File: testbench/test_watchdog_timer_timed_unlock.sv */
// Self-checking bench for the watchdog timer with timed unlock
`timescale 1ns/1ps
`include "wdt_map.svh"

module test_watchdog_timer_timed_unlock;
  import wdt_pkg::*;
  localparam int DIV = 2;
  localparam int BASE = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic always_on_fuse_i = 1'b0;
  logic restart_instruction_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic dog_reset_o;
  logic dog_reset_flag_o;
  wdt_ctrl_t ctrl_o;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int pulses = 0;
  int snap;
  int n;
  int exp_n;
  logic [31:0] rd;
  logic last_pulse = 1'b0;
  // Reference model of the control byte
  int m_open = -100;
  logic m_en = 1'b0;
  logic [2:0] m_per = 3'h0;

  wdt_timed #(.OSC_DIV(DIV), .BASE_CYCLES(BASE)) wdt_timed_inst (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .always_on_fuse_i(always_on_fuse_i),
    .restart_instruction_i(restart_instruction_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dog_reset_o(dog_reset_o),
    .dog_reset_flag_o(dog_reset_flag_o), .ctrl_o(ctrl_o)
  );

  // 25 MHz system clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int w;
    w = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 20);
    rd = wb_dat_o;
    // Model follows the write on the edge where it lands
    if (wb_ack_o === 1'b1 && we && a == `WDT_CTRL_ADR) begin
      if (cycles - m_open <= 4) begin
        m_per = d[2:0];
        m_en = d[3];
      end else if (d[3]) begin
        m_en = 1'b1;
      end
      m_open = (d[4] && d[3]) ? cycles : -100;
    end
    if (wb_ack_o !== 1'b1) chk(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
    if (a == `WDT_CTRL_ADR) begin
      chk({28'h0, rd[3:0]}, {28'h0, m_en | always_on_fuse_i, m_per});
    end
  endtask

  task automatic restart();
    restart_instruction_i <= 1'b1;
    @(posedge clk_i);
    restart_instruction_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Pulse width, pulse count and hang limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (dog_reset_o === 1'b1) pulses <= pulses + 1;
    if (dog_reset_o === 1'b1 && last_pulse === 1'b1) begin
      chk(32'h1, 32'h0);
    end
    last_pulse <= dog_reset_o;
    if (cycles > 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(10574));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    rdc(`WDT_CTRL_ADR, 8'h00);
    rdc(`WDT_STAT_ADR, 8'h00);
    rdc({6'($urandom_range(2, 63)), 2'b00}, 8'h00);
    wb(1'b1, `WDT_CTRL_ADR, 8'he9);
    rdc(`WDT_CTRL_ADR, 8'h08);
    wb(1'b1, `WDT_CTRL_ADR, 8'h00);
    rdc(`WDT_CTRL_ADR, 8'h08);
    // Restarts at random spacing under the 32-cycle period
    snap = pulses;
    repeat (20) begin
      restart();
      repeat ($urandom_range(3, 16)) @(posedge clk_i);
    end
    chk(pulses, snap);
    // Late second write falls outside the window
    restart();
    wb(1'b1, `WDT_CTRL_ADR, 8'h18);
    rdc(`WDT_CTRL_ADR, 8'h18);
    repeat (6) @(posedge clk_i);
    wb(1'b1, `WDT_CTRL_ADR, 8'h00);
    rdc(`WDT_CTRL_ADR, 8'h08);
    wb(1'b1, `WDT_CTRL_ADR, 8'h18);
    wb(1'b1, `WDT_CTRL_ADR, 8'h00);
    rdc(`WDT_CTRL_ADR, 8'h00);
    snap = pulses;
    repeat (80) @(posedge clk_i);
    chk(pulses, snap);
    // Every period code, timed from a restart to the pulse
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, `WDT_CTRL_ADR, 8'h18);
      wb(1'b1, `WDT_CTRL_ADR, 8'(8 + p));
      rdc(`WDT_CTRL_ADR, 8'(8 + p));
      restart();
      n = 0;
      exp_n = (BASE << p) * DIV;
      while (dog_reset_o !== 1'b1 && n < 5000) begin
        @(posedge clk_i);
        n++;
      end
      chk(32'(n >= exp_n - DIV - 4 && n <= exp_n + DIV + 4), 32'h1);
      rdc(`WDT_STAT_ADR, 8'h08);
      chk({31'h0, dog_reset_flag_o}, 32'h1);
    end
    wb(1'b1, `WDT_CTRL_ADR, 8'h18);
    wb(1'b1, `WDT_CTRL_ADR, 8'h07);
    rdc(`WDT_CTRL_ADR, 8'h07);
    // Chip reset into level two keeps the flag
    m_en = 1'b0;
    m_per = 3'h0;
    m_open = -100;
    always_on_fuse_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`WDT_STAT_ADR, 8'h08);
    wb(1'b1, `WDT_STAT_ADR, 8'h00);
    rdc(`WDT_STAT_ADR, 8'h00);
    chk({31'h0, dog_reset_flag_o}, 32'h0);
    rdc(`WDT_CTRL_ADR, 8'h08);
    wb(1'b1, `WDT_CTRL_ADR, 8'h18);
    wb(1'b1, `WDT_CTRL_ADR, 8'h02);
    rdc(`WDT_CTRL_ADR, 8'h0a);
    chk({27'h0, ctrl_o}, 32'h0000_000a);
    report_and_stop();
  end
endmodule
